/* include/host_link_pkg.sv */
// shared constants and packet types for the host-side packet link
package host_link_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int BAUD_SLOW = 19200;
   localparam int BAUD_FAST = 115200;
   localparam int DIV_W = 11;
   localparam logic [DIV_W-1:0] BIT_CYC_SLOW = DIV_W'(CLK_HZ / BAUD_SLOW);
   localparam logic [DIV_W-1:0] BIT_CYC_FAST = DIV_W'(CLK_HZ / BAUD_FAST);
   localparam int UART_DATA_BITS = 8;
   localparam logic [3:0] UART_LAST_BIT = 4'h9;
   localparam int ACK_TIMEOUT_MS = 250;
   localparam int ACK_TIMEOUT_CYC = (CLK_HZ / 1000) * ACK_TIMEOUT_MS;
   localparam int TIMER_W = 23;
   localparam int DEFAULT_RETRIES = 3;
   localparam int MAX_PAYLOAD = 18;
   localparam logic [4:0] MAX_LEN = 5'h12;
   localparam int PAYLOAD_W = MAX_PAYLOAD * 8;
   localparam logic [1:0] CLS_CMD = 2'h0;
   localparam logic [1:0] CLS_RESP = 2'h1;
   localparam logic [1:0] CLS_REPORT = 2'h2;
   localparam logic [1:0] CLS_ERROR = 2'h3;
   localparam logic [5:0] KEY_REPORT_CODE = 6'h00;
   localparam logic [4:0] KEY_REPORT_LEN = 5'h01;
   localparam logic [7:0] KEY_CODE_MIN = 8'h01;
   localparam logic [7:0] KEY_CODE_MAX = 8'h0c;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_XOROUT = 16'hffff;

   typedef struct packed {
      logic [5:0] code;
      logic [4:0] len;
      logic [PAYLOAD_W-1:0] payload;
   } cmd_req_t;

   typedef struct packed {
      logic [1:0] cls;
      logic [5:0] code;
      logic [4:0] len;
      logic [PAYLOAD_W-1:0] payload;
   } pkt_t;
endpackage

/* hw/crc16_unit.sv */
// byte-wide 16-bit check accumulator, reflected form
`timescale 1ns/1ps
`default_nettype none
module crc16_unit (
   input wire logic clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic en,
   input wire logic [7:0] data,
   output logic [15:0] crc
);
   import host_link_pkg::*;

   logic [15:0] crc_reg;
   logic [15:0] stage [0:8];

   assign stage[0] = crc_reg;
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         logic [15:0] mix;
         assign mix = stage[i] ^ {8'h00, (i == 0) ? data : 8'h00};
         assign stage[i+1] = mix[0] ? ((mix >> 1) ^ CRC_POLY) : (mix >> 1);
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         crc_reg <= CRC_INIT;
      end else if (en) begin
         crc_reg <= stage[8];
      end
   end

   assign crc = crc_reg ^ CRC_XOROUT;
endmodule
`default_nettype wire

/* hw/host_packet_link.sv */
// host-side packet framer: sends commands, parses device packets
`timescale 1ns/1ps
`default_nettype none
module host_packet_link #(
   parameter int TIMEOUT_CYC = host_link_pkg::ACK_TIMEOUT_CYC,
   parameter int MAX_RETRIES = host_link_pkg::DEFAULT_RETRIES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic baud_fast,
   input wire host_link_pkg::cmd_req_t cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   output logic txd,
   input wire logic rxd,
   output host_link_pkg::pkt_t rx_pkt,
   output logic pkt_valid,
   output logic ack_valid,
   output logic ack_error,
   output logic report_valid,
   output logic key_valid,
   output logic [7:0] key_code,
   output logic fault
);
   import host_link_pkg::*;

   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_LOAD = 2'h1,
      TX_SHIFT = 2'h2,
      TX_WAIT = 2'h3
   } tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_START = 2'h1,
      RX_BITS = 2'h2,
      RX_STOP = 2'h3
   } rx_state_t;

   typedef enum logic [2:0] {
      P_TYPE = 3'h0,
      P_LEN = 3'h1,
      P_DATA = 3'h2,
      P_CRCL = 3'h3,
      P_CRCH = 3'h4
   } parse_state_t;

   ////////////////////////////////////////////////////////////////////
   // bit timing
   logic [DIV_W-1:0] bit_cyc;
   // rate select
   // slow default rate
   assign bit_cyc = baud_fast ? BIT_CYC_FAST : BIT_CYC_SLOW;

   ////////////////////////////////////////////////////////////////////
   // transmit side
   tx_state_t tx_state_reg;
   cmd_req_t cmd_reg;
   logic [4:0] idx_reg;
   logic [9:0] tx_shift_reg;
   logic [3:0] tx_bit_reg;
   logic [DIV_W-1:0] tx_div_reg;
   logic tx_tick;
   logic [TIMER_W-1:0] timer_reg;
   logic [3:0] retry_reg;
   logic txd_reg;
   logic fault_reg;
   logic [7:0] tx_byte;
   logic [4:0] dsel;
   logic [15:0] tx_crc;
   logic tx_crc_en;
   logic ack_hit;
   logic timeout;
   logic len_ok;

   assign len_ok = cmd.len <= MAX_LEN;
   // one command outstanding
   // wait for answer
   assign cmd_ready = (tx_state_reg == TX_IDLE) && len_ok;
   assign tx_tick = (tx_div_reg == bit_cyc - 1'b1);
   assign dsel = 5'(idx_reg - 5'h02);
   assign timeout = (timer_reg == TIMER_W'(TIMEOUT_CYC - 1));

   // byte sequence of one frame
   always_comb begin
      if (idx_reg == 5'h00) begin
         tx_byte = {CLS_CMD, cmd_reg.code};
      end else if (idx_reg == 5'h01) begin
         tx_byte = {3'h0, cmd_reg.len};
      end else if (idx_reg < 5'(cmd_reg.len + 5'h02)) begin
         tx_byte = cmd_reg.payload[{dsel, 3'b000} +: 8];
      end else if (idx_reg == 5'(cmd_reg.len + 5'h02)) begin
         tx_byte = tx_crc[7:0];
      end else begin
         tx_byte = tx_crc[15:8];
      end
   end

   assign tx_crc_en = (tx_state_reg == TX_LOAD) && (idx_reg < 5'(cmd_reg.len + 5'h02));

   crc16_unit u_tx_crc (
      .clk(clk),
      .rst(rst),
      .clear(tx_state_reg == TX_IDLE || (tx_state_reg == TX_WAIT && timeout)),
      .en(tx_crc_en),
      .data(tx_byte),
      .crc(tx_crc)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_state_reg <= TX_IDLE;
         cmd_reg <= '0;
         idx_reg <= 5'h00;
         tx_shift_reg <= 10'h3ff;
         tx_bit_reg <= 4'h0;
         tx_div_reg <= '0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  cmd_reg <= cmd;
                  idx_reg <= 5'h00;
                  tx_state_reg <= TX_LOAD;
               end
            end
            TX_LOAD: begin
               tx_shift_reg <= {1'b1, tx_byte, 1'b0};
               tx_bit_reg <= 4'h0;
               tx_div_reg <= '0;
               tx_state_reg <= TX_SHIFT;
            end
            TX_SHIFT: begin
               if (tx_tick) begin
                  tx_div_reg <= '0;
                  tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                  tx_bit_reg <= tx_bit_reg + 4'h1;
                  if (tx_bit_reg == UART_LAST_BIT) begin
                     idx_reg <= idx_reg + 5'h01;
                     tx_state_reg <= (idx_reg == 5'(cmd_reg.len + 5'h03)) ? TX_WAIT : TX_LOAD;
                  end
               end else begin
                  tx_div_reg <= tx_div_reg + 1'b1;
               end
            end
            TX_WAIT: begin
               if (ack_hit) begin
                  tx_state_reg <= TX_IDLE;
               end else if (timeout) begin
                  idx_reg <= 5'h00;
                  tx_state_reg <= (retry_reg == 4'(MAX_RETRIES)) ? TX_IDLE : TX_LOAD;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // line driver, idle high
   always_ff @(posedge clk) begin
      if (rst) begin
         txd_reg <= 1'b1;
      end else begin
         txd_reg <= (tx_state_reg == TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
      end
   end
   assign txd = txd_reg;

   // answer timer and retry count
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_reg <= '0;
         retry_reg <= 4'h0;
         fault_reg <= 1'b0;
      end else if (tx_state_reg == TX_IDLE) begin
         timer_reg <= '0;
         if (cmd_valid && cmd_ready) begin
            retry_reg <= 4'h0;
            fault_reg <= 1'b0;
         end
      end else if (tx_state_reg == TX_WAIT) begin
         timer_reg <= timeout ? '0 : timer_reg + 1'b1;
         if (timeout && !ack_hit) begin
            if (retry_reg == 4'(MAX_RETRIES)) begin
               fault_reg <= 1'b1;
            end else begin
               retry_reg <= retry_reg + 4'h1;
            end
         end
      end else begin
         timer_reg <= '0;
      end
   end
   assign fault = fault_reg;

   ////////////////////////////////////////////////////////////////////
   // receive side
   rx_state_t rx_state_reg;
   logic [DIV_W-1:0] rx_div_reg;
   logic [2:0] rx_bit_reg;
   logic [7:0] rx_sh_reg;
   logic rx_byte_valid;

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_state_reg <= RX_IDLE;
         rx_div_reg <= '0;
         rx_bit_reg <= 3'h0;
         rx_sh_reg <= 8'h00;
         rx_byte_valid <= 1'b0;
      end else begin
         rx_byte_valid <= 1'b0;
         rx_div_reg <= rx_div_reg + 1'b1;
         case (rx_state_reg)
            RX_IDLE: begin
               rx_div_reg <= '0;
               if (!rxd) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               if (rx_div_reg == (bit_cyc >> 1)) begin
                  rx_div_reg <= '0;
                  rx_bit_reg <= 3'h0;
                  rx_state_reg <= rxd ? RX_IDLE : RX_BITS;
               end
            end
            RX_BITS: begin
               if (rx_div_reg == bit_cyc - 1'b1) begin
                  rx_div_reg <= '0;
                  rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if (rx_bit_reg == 3'(UART_DATA_BITS - 1)) begin
                     rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (rx_div_reg == bit_cyc - 1'b1) begin
                  rx_byte_valid <= rxd;
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // packet parser
   parse_state_t p_state_reg;
   pkt_t p_pkt_reg;
   logic [4:0] p_cnt_reg;
   logic [7:0] p_crcl_reg;
   logic [15:0] rx_crc;
   logic p_good;

   crc16_unit u_rx_crc (
      .clk(clk),
      .rst(rst),
      .clear(p_state_reg == P_TYPE && !rx_byte_valid),
      .en(rx_byte_valid && p_state_reg <= P_DATA),
      .data(rx_sh_reg),
      .crc(rx_crc)
   );

   assign p_good = rx_byte_valid && (p_state_reg == P_CRCH) && ({rx_sh_reg, p_crcl_reg} == rx_crc);

   always_ff @(posedge clk) begin
      if (rst) begin
         p_state_reg <= P_TYPE;
         p_pkt_reg <= '0;
         p_cnt_reg <= 5'h00;
         p_crcl_reg <= 8'h00;
      end else if (rx_byte_valid) begin
         case (p_state_reg)
            P_TYPE: begin
               p_pkt_reg <= '0;
               p_pkt_reg.cls <= rx_sh_reg[7:6];
               p_pkt_reg.code <= rx_sh_reg[5:0];
               p_state_reg <= P_LEN;
            end
            P_LEN: begin
               // length over 18 drops the frame
               p_pkt_reg.len <= rx_sh_reg[4:0];
               p_cnt_reg <= 5'h00;
               if (rx_sh_reg > 8'(MAX_LEN)) begin
                  p_state_reg <= P_TYPE;
               end else begin
                  p_state_reg <= (rx_sh_reg == 8'h00) ? P_CRCL : P_DATA;
               end
            end
            P_DATA: begin
               p_pkt_reg.payload[{p_cnt_reg, 3'b000} +: 8] <= rx_sh_reg;
               p_cnt_reg <= p_cnt_reg + 5'h01;
               if (p_cnt_reg == p_pkt_reg.len - 5'h01) begin
                  p_state_reg <= P_CRCL;
               end
            end
            P_CRCL: begin
               p_crcl_reg <= rx_sh_reg;
               p_state_reg <= P_CRCH;
            end
            P_CRCH: begin
               p_state_reg <= P_TYPE;
            end
            default: p_state_reg <= P_TYPE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // classification of good packets
   logic is_ack;
   logic is_key;
   assign is_ack = (p_pkt_reg.cls == CLS_RESP) || (p_pkt_reg.cls == CLS_ERROR);
   assign ack_hit = pkt_valid && ack_valid && (tx_state_reg == TX_WAIT);
   assign is_key = (p_pkt_reg.cls == CLS_REPORT) && (p_pkt_reg.code == KEY_REPORT_CODE)
      && (p_pkt_reg.len == KEY_REPORT_LEN)
      && (p_pkt_reg.payload[7:0] >= KEY_CODE_MIN) && (p_pkt_reg.payload[7:0] <= KEY_CODE_MAX);

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_pkt <= '0;
         pkt_valid <= 1'b0;
         ack_valid <= 1'b0;
         ack_error <= 1'b0;
         report_valid <= 1'b0;
         key_valid <= 1'b0;
         key_code <= 8'h00;
      end else begin
         pkt_valid <= p_good;
         ack_valid <= p_good && is_ack && (p_pkt_reg.code == cmd_reg.code) && (tx_state_reg == TX_WAIT);
         ack_error <= p_good && (p_pkt_reg.cls == CLS_ERROR);
         report_valid <= p_good && (p_pkt_reg.cls == CLS_REPORT);
         key_valid <= p_good && is_key;
         if (p_good) begin
            rx_pkt <= p_pkt_reg;
            if (is_key) begin
               key_code <= p_pkt_reg.payload[7:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_frame_start;
      (tx_state_reg == TX_LOAD) && (idx_reg == 5'h00);
   endsequence
   sequence s_start_bit;
      ##2 !txd;
   endsequence

   AST_START_LOW: assert property (s_frame_start |-> s_start_bit) else $error("start bit missing");
   AST_RATE: assert property ((tx_state_reg == TX_SHIFT) && !tx_tick && (tx_div_reg != '0)
      |=> $stable(txd)) else $error("line changed inside a bit period");
   AST_TYPE_CLASS: assert property ((tx_state_reg == TX_LOAD) && (idx_reg == 5'h00)
      |=> tx_shift_reg[8:7] == CLS_CMD) else $error("command class not 00");
   AST_LEN_MAX: assert property (cmd_valid && cmd_ready |-> cmd.len <= MAX_LEN) else $error("length over 18");
   AST_CRC_LO: assert property ((tx_state_reg == TX_LOAD) && (idx_reg == 5'(cmd_reg.len + 5'h02))
      |-> tx_byte == tx_crc[7:0]) else $error("check low byte not first");
   AST_HOLD_CMD: assert property ((tx_state_reg == TX_WAIT) |-> !cmd_ready) else $error("command while waiting");
   AST_RETRY: assert property ((tx_state_reg == TX_WAIT) && timeout && !ack_hit && (retry_reg < 4'(MAX_RETRIES))
      |=> (tx_state_reg == TX_LOAD) && (idx_reg == 5'h00)) else $error("no resend after timeout");
   AST_ACK_CODE: assert property (ack_valid |-> $past(p_pkt_reg.code) == cmd_reg.code) else $error("answer code mismatch");
   AST_KEY_RANGE: assert property (key_valid |-> key_code >= KEY_CODE_MIN && key_code <= KEY_CODE_MAX
      && rx_pkt.cls == CLS_REPORT) else $error("key code out of range");
   AST_BAD_DROP: assert property (rx_byte_valid && (p_state_reg == P_CRCH) && !p_good
      |=> !pkt_valid && (p_state_reg == P_TYPE)) else $error("bad packet delivered");
endmodule
`default_nettype wire

/* tb/dev_model.sv */
// behavioural display module answering host command packets
`timescale 1ns/1ps
`default_nettype none
module dev_model
   import host_link_pkg::*;
(
   input wire logic clk,
   input wire logic fast,
   input wire logic from_host,
   output logic to_host,
   input wire logic mute,
   input wire logic bad_crc,
   input wire logic key_go,
   input wire logic [7:0] key_ev,
   output logic [7:0] rx_cnt,
   output logic [7:0] bad_cnt
);
   logic [7:0] t, n, lo, hi;
   logic [7:0] pl [0:17];
   logic [15:0] c;
   logic tx_busy;

   ////////////////////////////////////////////////////////////////////////////
   // check accumulate
   function automatic logic [15:0] crc_step(input logic [15:0] cin, input logic [7:0] d);
      logic [15:0] r;
      r = cin ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic int bit_cyc();
      return fast ? int'(BIT_CYC_FAST) : int'(BIT_CYC_SLOW);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic rx_byte(output logic [7:0] b);
      @(negedge clk iff from_host === 1'b0);
      repeat (bit_cyc() / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc()) @(negedge clk);
         b[i] = from_host;
      end
      repeat (bit_cyc()) @(negedge clk);
      if (from_host !== 1'b1) begin
         bad_cnt = bad_cnt + 8'h01;
      end
   endtask

   task automatic tx_byte(input logic [7:0] b);
      to_host = 1'b0;
      repeat (bit_cyc()) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
         to_host = b[i];
         repeat (bit_cyc()) @(negedge clk);
      end
      to_host = 1'b1;
      repeat (bit_cyc()) @(negedge clk);
   endtask

   task automatic tx_pkt(input logic [7:0] ty, input logic [7:0] len, input logic keyed, input logic bad);
      logic [15:0] k;
      logic [7:0] d;
      wait (tx_busy == 1'b0);
      tx_busy = 1'b1;
      @(negedge clk);
      k = crc_step(crc_step(CRC_INIT, ty), len);
      tx_byte(ty);
      tx_byte(len);
      for (int i = 0; i < len; i++) begin
         d = keyed ? key_ev : pl[i];
         k = crc_step(k, d);
         tx_byte(d);
      end
      k = k ^ CRC_XOROUT ^ {15'h0000, bad};
      tx_byte(k[7:0]);
      tx_byte(k[15:8]);
      tx_busy = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      to_host = 1'b1;
      tx_busy = 1'b0;
      rx_cnt = 8'h00;
      bad_cnt = 8'h00;
      forever begin
         rx_byte(t);
         rx_byte(n);
         c = crc_step(crc_step(CRC_INIT, t), n);
         for (int i = 0; i < n && i < MAX_PAYLOAD; i++) begin
            rx_byte(pl[i]);
            c = crc_step(c, pl[i]);
         end
         rx_byte(lo);
         rx_byte(hi);
         if ({hi, lo} !== (c ^ CRC_XOROUT) || t[7:6] !== CLS_CMD || n > 8'h12) begin
            bad_cnt = bad_cnt + 8'h01;
         end
         rx_cnt = rx_cnt + 8'h01;
         // frame with bad check gets no answer
         if (mute !== 1'b1 && {hi, lo} === (c ^ CRC_XOROUT)) begin
            if (t[5:0] == 6'h3f) begin
               tx_pkt({CLS_ERROR, t[5:0]}, 8'h00, 1'b0, bad_crc);
            end else begin
               tx_pkt({CLS_RESP, t[5:0]}, n, 1'b0, bad_crc);
            end
         end
      end
   end

   // zero event code sends a sensor report instead
   always @(posedge key_go) begin
      tx_pkt(key_ev == 8'h00 ? 8'h82 : 8'h80, key_ev == 8'h00 ? 8'h04 : 8'h01, 1'b1, 1'b0);
   end
endmodule
`default_nettype wire

/* tb/host_packet_link_tb.sv */
// self-checking bench for the host packet link
`timescale 1ns/1ps
`default_nettype none
module host_packet_link_tb;
   import host_link_pkg::*;
   localparam int TMO = 12000;
   localparam int RETRY = 1;
   logic clk, rst, baud_fast, cmd_valid, cmd_ready, txd, rxd;
   cmd_req_t cmd;
   pkt_t rx_pkt;
   logic pkt_valid, ack_valid, ack_error, report_valid, key_valid, fault;
   logic [7:0] key_code, rx_cnt, bad_cnt, key_ev;
   logic mute, bad_crc, key_go;
   int failures, n_tests;

   host_packet_link #(.TIMEOUT_CYC(TMO), .MAX_RETRIES(RETRY)) i_dut (.clk(clk), .rst(rst),
      .baud_fast(baud_fast), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .txd(txd),
      .rxd(rxd), .rx_pkt(rx_pkt), .pkt_valid(pkt_valid), .ack_valid(ack_valid), .ack_error(ack_error),
      .report_valid(report_valid), .key_valid(key_valid), .key_code(key_code), .fault(fault));
   dev_model i_dev (.clk(clk), .fast(baud_fast), .from_host(txd), .to_host(rxd), .mute(mute),
      .bad_crc(bad_crc), .key_go(key_go), .key_ev(key_ev), .rx_cnt(rx_cnt), .bad_cnt(bad_cnt));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("Error %s expected %h got %h", what, exp, got);
         failures++;
      end
   endtask

   task automatic send_cmd(input logic [5:0] code, input logic [4:0] len);
      int k;
      @(negedge clk);
      cmd.code = code;
      cmd.len = len;
      for (int i = 0; i < MAX_PAYLOAD; i++) begin
         cmd.payload[8*i +: 8] = 8'ha0 + 8'(i);
      end
      cmd_valid = 1'b1;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 100) begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      chk("cmd_ready busy", 0, cmd_ready);
      k = 0;
      while (txd !== 1'b0 && k < 10) begin
         @(negedge clk);
         k++;
      end
      chk("start delay", 2, k);
      k = 0;
      while (txd === 1'b0 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      chk("start bit cycles", CLK_HZ / (baud_fast ? BAUD_FAST : BAUD_SLOW), k);
   endtask

   task automatic wait_pkt();
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (pkt_valid !== 1'b1 && k < 30000);
      chk("pkt_valid", 1, pkt_valid);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ping_key();
      key_ev = KEY_CODE_MIN;
      send_cmd(6'h05, 5'h01);
      key_go = 1'b1;
      wait_pkt();
      chk("report_valid", 1, report_valid);
      chk("key_valid", 1, key_valid);
      chk("key_code", 8'h01, key_code);
      chk("report ack", 0, ack_valid);
      chk("report type", 8'h80, {rx_pkt.cls, rx_pkt.code});
      key_go = 1'b0;
      wait_pkt();
      chk("ack_valid", 1, ack_valid);
      chk("ack_error", 0, ack_error);
      chk("resp type", {CLS_RESP, 6'h05}, {rx_pkt.cls, rx_pkt.code});
      chk("resp len", 1, rx_pkt.len);
      chk("resp payload", 8'ha0, rx_pkt.payload[7:0]);
      @(negedge clk);
      chk("pulse width", 0, pkt_valid);
      chk("cmd_ready idle", 1, cmd_ready);
      chk("device saw bad frame", 0, bad_cnt);
   endtask

   task automatic t_error();
      send_cmd(6'h3f, 5'h00);
      wait_pkt();
      chk("error ack", 1, ack_valid);
      chk("ack_error", 1, ack_error);
      chk("error type", 8'hff, {rx_pkt.cls, rx_pkt.code});
   endtask

   task automatic t_retry_fault();
      int k;
      logic [7:0] r0;
      logic seen;
      bad_crc = 1'b1;
      r0 = rx_cnt;
      send_cmd(6'h03, 5'h00);
      seen = 1'b0;
      k = 0;
      while (fault !== 1'b1 && k < 60000) begin
         @(negedge clk);
         if ((pkt_valid === 1'b1 || cmd_ready === 1'b1) && fault !== 1'b1) begin
            seen = 1'b1;
         end
         k++;
      end
      chk("fault", 1, fault);
      chk("fault after waits", 1, k > 2 * TMO);
      chk("bad check dropped", 0, seen);
      chk("sends", 1 + RETRY, rx_cnt - r0);
      bad_crc = 1'b0;
   endtask

   task automatic t_long_refused();
      @(negedge clk);
      cmd.len = 5'h13;
      @(negedge clk);
      chk("len 19 ready", 0, cmd_ready);
      cmd.len = 5'h12;
      @(negedge clk);
      chk("len 18 ready", 1, cmd_ready);
   endtask

   task automatic t_slow();
      baud_fast = 1'b0;
      mute = 1'b1;
      send_cmd(6'h01, 5'h00);
      chk("fault cleared", 0, fault);
   endtask

   task automatic t_sensor();
      key_ev = 8'h00;
      key_go = 1'b1;
      wait_pkt();
      chk("sensor report", 1, report_valid);
      chk("sensor not key", 0, key_valid);
      chk("sensor type", 8'h82, {rx_pkt.cls, rx_pkt.code});
      chk("sensor len", 4, rx_pkt.len);
      key_go = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      baud_fast = 1'b1;
      cmd = '0;
      cmd_valid = 1'b0;
      mute = 1'b0;
      bad_crc = 1'b0;
      key_go = 1'b0;
      key_ev = 8'h00;
      failures = 0;
      n_tests = 0;
      repeat (12) @(negedge clk);
      chk("reset txd", 1, txd);
      chk("reset fault", 0, fault);
      rst = 1'b0;
      t_ping_key();
      t_error();
      t_retry_fault();
      t_long_refused();
      t_sensor();
      t_slow();
      summarize();
   end

   initial begin
      repeat (110000) @(posedge clk);
      $display("Error watchdog expected done got timeout");
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
